// file: rtl/sop_regs.svh
`ifndef SOP_REGS_SVH
`define SOP_REGS_SVH
// Register offsets on the CPU and debug register port
`define SOP_ADDR_DBG 4'h0
`define SOP_ADDR_OPT1 4'h1
`define SOP_ADDR_OPT2 4'h2
`define SOP_ADDR_IDH 4'h3
`define SOP_ADDR_IDL 4'h4
`define SOP_ADDR_RSC 4'h5
// Field positions
`define SOP_DBG_BIT 0
// Reset values
`define SOP_OPT1_RST 8'hC0
`define SOP_OPT2_RST 8'h00
`define SOP_ZERO_BYTE 8'h00
// Watchdog clearing sequence bytes
`define SOP_CLR_FIRST 8'h55
`define SOP_CLR_SECOND 8'hAA
// Watchdog timeout codes
`define SOP_TO_OFF 2'h0
`define SOP_TO_ONE 2'h1
`define SOP_TO_TWO 2'h2
// Overflow counts on the 1 kHz clock
`define SOP_LPO_OVF1 19'h00020
`define SOP_LPO_OVF2 19'h00100
`define SOP_LPO_OVF3 19'h00400
// Counter steps
`define SOP_CNT_ONE 19'h00001
`define SOP_DIV_ONE 3'h1
`define SOP_DIV_OFF 3'h0
`endif

// file: rtl/sop_pkg.sv
package sop_pkg;
  // First options register layout
  typedef struct packed {
    logic [1:0] watchdog_timeout_sel;
    logic stop_allow;
    logic serial2_location_sel;
    logic twowire_location_sel;
    logic [2:0] rsvd;
  } sop_opt1_t;
  // Second options register layout
  typedef struct packed {
    logic watchdog_clock_sel;
    logic watchdog_window_en;
    logic rsvd5;
    logic converter_trigger_sel;
    logic rsvd3;
    logic [2:0] clock_out_divide;
  } sop_opt2_t;
  // Whole state of the register bank
  typedef struct packed {
    sop_opt1_t opt1;
    logic opt1_lock;
    sop_opt2_t opt2;
    logic opt2_lock;
    logic [18:0] wd_cnt;
    logic seq_armed;
    logic [2:0] lpo_sync;
    logic lpo_level;
    logic [7:0] rdata;
    logic dbg_rst;
    logic wd_rst;
    logic illegal_opcode_reset_rst;
  } sop_state_t;
  // Clock output divider state
  typedef struct packed {
    logic [2:0] cnt;
    logic clk;
    logic oe; // Registered pin enable
  } sop_div_t;
endpackage : sop_pkg

// file: rtl/sop_clkdiv.sv
`timescale 1ns/1ns
`default_nettype none
`include "sop_regs.svh"
module sop_clkdiv
  import sop_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Divide select
  input wire logic [2:0] divide_i,
  // Clock output pin
  output logic clk_o,
  output logic clk_oe_o
);
  sop_div_t s; // Registered state
  sop_div_t next_s; // Next state

  ////////////////////////////////////////////////////////////////////////
  // Toggle every divide_i bus cycles, giving bus / (2 * divide_i)
  always_comb
  begin
    next_s = s;
    // Pin enable follows the divide field one cycle later, with the parked level
    next_s.oe = (divide_i != `SOP_DIV_OFF);
    if (divide_i == `SOP_DIV_OFF)
    begin
      // Output parked low while disabled
      next_s.cnt = `SOP_DIV_OFF;
      next_s.clk = 1'b0;
    end
    else if (s.cnt >= divide_i - `SOP_DIV_ONE)
    begin
      // Half period done
      next_s.cnt = `SOP_DIV_OFF;
      next_s.clk = ~s.clk;
    end
    else
    begin
      next_s.cnt = s.cnt + `SOP_DIV_ONE;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign clk_o = s.clk;
  assign clk_oe_o = s.oe;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_div_off_low: assert property (divide_i == `SOP_DIV_OFF |=> !clk_o)
    else $error("clock out not parked low");
  a_div_half_period: assert property (
    (divide_i != `SOP_DIV_OFF && s.cnt == divide_i - `SOP_DIV_ONE) |=> (clk_o != $past(clk_o)))
    else $error("clock out missed its toggle");
endmodule : sop_clkdiv
`default_nettype wire

// file: rtl/sop_top.sv
// Summary of operation
// - User writes to debug reset register ignored
// - Debug reset register always reads zero
// - Debug host writing bit0 forces reset
// - First options register is write-once, readable
// - Timeout field selects period; zero disables
// - Slow clock overflows at 32, 256, 1024
// - Clock select bit picks slow or bus
// - Window bit selects windowed watchdog mode
// - Early write in window mode causes reset
// - Window opens at three quarters of count
// - STOP while disallowed gives illegal opcode reset
// - Serial2 location bit routes its pins
// - Two-wire location bit routes its pins
// - Trigger select picks counter or pin
// - Zero divide field disables clock output
// - Clock out is bus over twice divide
// - Read-only part number identification registers
// - Identification holds a silicon revision number
// - 0x55 then 0xAA clears the watchdog
// - Any other value written resets when enabled
`timescale 1ns/1ns
`default_nettype none
`include "sop_regs.svh"
module sop_top
  import sop_pkg::*;
#(
  parameter int BUS_OVF1 = 8192, // Bus clock overflow, timeout 1
  parameter int BUS_OVF2 = 65536, // Bus clock overflow, timeout 2
  parameter int BUS_OVF3 = 262144, // Bus clock overflow, timeout 3
  parameter logic [11:0] PART_NUM = 12'hA5C, // Arbitrary value
  parameter logic [3:0] REV_NUM = 4'h1 // Arbitrary value
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // CPU register port
  input wire logic [3:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  // Background debug write port
  input wire logic [3:0] bdm_addr_i,
  input wire logic bdm_wr_i,
  input wire logic [7:0] bdm_wdata_i,
  // Core events and 1 kHz clock pin
  input wire logic lpo_clk_i,
  input wire logic stop_exec_i,
  // Reset requests
  output logic debug_reset_o,
  output logic watchdog_reset_o,
  output logic illegal_opcode_reset_o,
  // Configuration outputs
  output logic stop_allow_o,
  output logic serial2_location_sel_o,
  output logic twowire_location_sel_o,
  output logic converter_trigger_sel_o,
  // Clock output on port A bit 0
  output logic port_a_bit0_o,
  output logic port_a_bit0_oe_o
);
  sop_state_t s; // Registered state
  sop_state_t next_s; // Next state
  logic wd_on; // Watchdog enabled
  logic lpo_agree; // Synchroniser stages agree
  logic lpo_rise; // Qualified 1 kHz rising edge
  logic wd_tick; // Watchdog count step
  logic [18:0] wd_limit; // Current overflow count
  logic [18:0] wd_open; // Current window open count
  logic wd_early; // Inside closed part of the window
  logic wr_rsc; // CPU write to reset cause address

  localparam sop_opt1_t OPT1_RST = `SOP_OPT1_RST;
  localparam sop_opt2_t OPT2_RST = `SOP_OPT2_RST;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Overflow count for the selected clock and timeout
  function automatic logic [18:0] ovf_count(input logic [1:0] sel, input logic bus);
    logic [18:0] r;
    r = `SOP_LPO_OVF3;
    unique case (sel)
      `SOP_TO_OFF: r = `SOP_LPO_OVF3;
      `SOP_TO_ONE: r = bus ? 19'(BUS_OVF1) : `SOP_LPO_OVF1;
      `SOP_TO_TWO: r = bus ? 19'(BUS_OVF2) : `SOP_LPO_OVF2;
      default: r = bus ? 19'(BUS_OVF3) : `SOP_LPO_OVF3;
    endcase
    return r;
  endfunction : ovf_count

  // Window opens after three quarters of the period
  function automatic logic [18:0] open_count(input logic [18:0] lim);
    return lim - (lim >> 2);
  endfunction : open_count

  ////////////////////////////////////////////////////////////////////////
  // Decoding used by the next-state logic
  always_comb
  begin
    wd_on = s.opt1.watchdog_timeout_sel != `SOP_TO_OFF;
    lpo_agree = s.lpo_sync[1] == s.lpo_sync[2];
    lpo_rise = lpo_agree && s.lpo_sync[2] && !s.lpo_level;
    // Bus clock steps every cycle, slow clock on its rising edges
    wd_tick = s.opt2.watchdog_clock_sel ? 1'b1 : lpo_rise;
    wd_limit = ovf_count(s.opt1.watchdog_timeout_sel, s.opt2.watchdog_clock_sel);
    wd_open = open_count(wd_limit);
    wd_early = s.opt2.watchdog_window_en && (s.wd_cnt < wd_open);
    wr_rsc = cpu_wr_i && (cpu_addr_i == `SOP_ADDR_RSC);
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_s = s;
    // Reset requests are single-cycle pulses
    next_s.dbg_rst = 1'b0;
    next_s.wd_rst = 1'b0;
    next_s.illegal_opcode_reset_rst = 1'b0;

    // 1 kHz pin through three stages
    next_s.lpo_sync = {s.lpo_sync[1:0], lpo_clk_i};
    if (lpo_agree)
    begin
      next_s.lpo_level = s.lpo_sync[2];
    end

    // Watchdog counter
    if (!wd_on)
    begin
      // Disabled: hold at zero
      next_s.wd_cnt = '0;
      next_s.seq_armed = 1'b0;
    end
    else if (wd_tick)
    begin
      if (s.wd_cnt >= wd_limit - `SOP_CNT_ONE)
      begin
        // Overflow
        next_s.wd_rst = 1'b1;
        next_s.wd_cnt = '0;
      end
      else
      begin
        next_s.wd_cnt = s.wd_cnt + `SOP_CNT_ONE;
      end
    end

    // CPU writes; a clear below wins over the count step
    if (cpu_wr_i)
    begin
      unique case (cpu_addr_i)
        `SOP_ADDR_DBG:
        begin
          // User program cannot reach the debug bit
          next_s.dbg_rst = next_s.dbg_rst;
        end
        `SOP_ADDR_OPT1:
        begin
          // Only the first write after reset is taken
          if (!s.opt1_lock)
          begin
            next_s.opt1 = cpu_wdata_i;
            next_s.opt1.rsvd = '0;
          end
          next_s.opt1_lock = 1'b1;
        end
        `SOP_ADDR_OPT2:
        begin
          // Trigger and divide stay writable
          next_s.opt2.converter_trigger_sel = cpu_wdata_i[4];
          next_s.opt2.clock_out_divide = cpu_wdata_i[2:0];
          if (!s.opt2_lock)
          begin
            next_s.opt2.watchdog_clock_sel = cpu_wdata_i[7];
            next_s.opt2.watchdog_window_en = cpu_wdata_i[6];
          end
          next_s.opt2_lock = 1'b1;
        end
        `SOP_ADDR_RSC:
        begin
          if (wd_on)
          begin
            if (wd_early)
            begin
              // Any write before the window opens
              next_s.wd_rst = 1'b1;
              next_s.seq_armed = 1'b0;
            end
            else if (cpu_wdata_i == `SOP_CLR_FIRST)
            begin
              // First byte of the clearing pair
              next_s.seq_armed = 1'b1;
            end
            else if (cpu_wdata_i == `SOP_CLR_SECOND)
            begin
              // Second byte clears only after the first
              if (s.seq_armed)
              begin
                next_s.wd_cnt = '0;
                next_s.wd_rst = 1'b0;
              end
              next_s.seq_armed = 1'b0;
            end
            else
            begin
              // Any other value
              next_s.wd_rst = 1'b1;
              next_s.seq_armed = 1'b0;
            end
          end
        end
        default:
        begin
          // Read-only or unmapped: no effect
          next_s.seq_armed = s.seq_armed;
        end
      endcase
    end

    // Debug host force reset
    if (bdm_wr_i && (bdm_addr_i == `SOP_ADDR_DBG) && bdm_wdata_i[`SOP_DBG_BIT])
    begin
      next_s.dbg_rst = 1'b1;
    end

    // STOP while not allowed is an illegal opcode
    if (stop_exec_i && !s.opt1.stop_allow)
    begin
      next_s.illegal_opcode_reset_rst = 1'b1;
    end

    // Registered read data
    next_s.rdata = `SOP_ZERO_BYTE;
    if (cpu_rd_i)
    begin
      unique case (cpu_addr_i)
        `SOP_ADDR_DBG: next_s.rdata = `SOP_ZERO_BYTE;
        `SOP_ADDR_OPT1: next_s.rdata = s.opt1;
        `SOP_ADDR_OPT2: next_s.rdata = s.opt2;
        `SOP_ADDR_IDH: next_s.rdata = {REV_NUM, PART_NUM[11:8]};
        `SOP_ADDR_IDL: next_s.rdata = PART_NUM[7:0];
        default: next_s.rdata = `SOP_ZERO_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.opt1 <= OPT1_RST;
      s.opt2 <= OPT2_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock output divider
  sop_clkdiv sop_clkdiv_inst (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .divide_i(s.opt2.clock_out_divide),
    .clk_o(port_a_bit0_o),
    .clk_oe_o(port_a_bit0_oe_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from state
  assign cpu_rdata_o = s.rdata;
  assign debug_reset_o = s.dbg_rst;
  assign watchdog_reset_o = s.wd_rst;
  assign illegal_opcode_reset_o = s.illegal_opcode_reset_rst;
  assign stop_allow_o = s.opt1.stop_allow;
  assign serial2_location_sel_o = s.opt1.serial2_location_sel;
  assign twowire_location_sel_o = s.opt1.twowire_location_sel;
  assign converter_trigger_sel_o = s.opt2.converter_trigger_sel;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Clearing pair written back to back, both outside the window
  sequence seq_first_byte;
    wr_rsc && wd_on && !wd_early && cpu_wdata_i == `SOP_CLR_FIRST;
  endsequence
  sequence seq_second_byte;
    wr_rsc && wd_on && !wd_early && cpu_wdata_i == `SOP_CLR_SECOND;
  endsequence

  a_dbg_user_ignored: assert property (
    (cpu_wr_i && cpu_addr_i == `SOP_ADDR_DBG && !bdm_wr_i) |=> !debug_reset_o)
    else $error("user write forced a debug reset");
  a_dbg_reads_zero: assert property (
    (cpu_rd_i && cpu_addr_i == `SOP_ADDR_DBG) |=> cpu_rdata_o == `SOP_ZERO_BYTE)
    else $error("debug reset register read nonzero");
  a_dbg_force_reset: assert property (
    (bdm_wr_i && bdm_addr_i == `SOP_ADDR_DBG && bdm_wdata_i[`SOP_DBG_BIT]) |=> debug_reset_o)
    else $error("debug force reset missing");
  a_opt1_write_once: assert property (
    (s.opt1_lock && cpu_wr_i && cpu_addr_i == `SOP_ADDR_OPT1) |=> $stable(s.opt1))
    else $error("locked options one changed");
  a_wd_off_idle: assert property (
    (!wd_on && !wr_rsc) |=> (s.wd_cnt == '0 && !watchdog_reset_o))
    else $error("disabled watchdog active");
  a_wd_overflow: assert property (
    (wd_on && s.opt2.watchdog_clock_sel && s.wd_cnt == wd_limit - `SOP_CNT_ONE
      && !(wr_rsc && s.seq_armed && cpu_wdata_i == `SOP_CLR_SECOND)) |=> watchdog_reset_o)
    else $error("bus clock overflow missed");
  a_window_early: assert property (
    (wr_rsc && wd_on && wd_early) |=> watchdog_reset_o)
    else $error("early write in window mode did not reset");
  a_clear_pair: assert property (seq_first_byte ##1 seq_second_byte |=> s.wd_cnt == '0)
    else $error("clearing pair did not clear watchdog");
  a_bad_value: assert property (
    (wr_rsc && wd_on && cpu_wdata_i != `SOP_CLR_FIRST && cpu_wdata_i != `SOP_CLR_SECOND) |=> watchdog_reset_o)
    else $error("bad value did not reset");
  a_stop_illegal: assert property (
    (stop_exec_i && !stop_allow_o) |=> illegal_opcode_reset_o)
    else $error("disallowed stop not trapped");
  a_opt2_lock: assert property (
    (s.opt2_lock && cpu_wr_i && cpu_addr_i == `SOP_ADDR_OPT2)
      |=> ($stable(s.opt2.watchdog_clock_sel) && $stable(s.opt2.watchdog_window_en)))
    else $error("locked watchdog bits changed");
  a_ident_high: assert property (
    (cpu_rd_i && cpu_addr_i == `SOP_ADDR_IDH) |=> cpu_rdata_o == {REV_NUM, PART_NUM[11:8]})
    else $error("ident high read wrong");
  a_ident_low: assert property (
    (cpu_rd_i && cpu_addr_i == `SOP_ADDR_IDL) |=> cpu_rdata_o == PART_NUM[7:0])
    else $error("ident low read wrong");
endmodule : sop_top
`default_nettype wire

// file: testbench/sop_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "sop_regs.svh"
// Compare two values, count it, report a mismatch at once
`define SOP_CHK(got, exp) \
  begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %0t mismatch got %0h exp %0h", $time, got, exp); end end
module sop_top_tb
  import sop_pkg::*;
;
  localparam logic [11:0] PN = 12'h3B7; // Arbitrary value
  localparam logic [3:0] RV = 4'h2; // Arbitrary value
  // Stimulus side
  logic ref_clk_i = 1'b0, rst_i = 1'b1, cpu_wr_i = 1'b0, cpu_rd_i = 1'b0, bdm_wr_i = 1'b0;
  logic lpo_clk_i = 1'b0, stop_exec_i = 1'b0;
  logic [3:0] cpu_addr_i = 4'h0, bdm_addr_i = 4'h0;
  logic [7:0] cpu_wdata_i = 8'h00, bdm_wdata_i = 8'h00;
  // Observed side
  logic [7:0] cpu_rdata_o, rv;
  logic debug_reset_o, watchdog_reset_o, illegal_opcode_reset_o, stop_allow_o;
  logic serial2_location_sel_o, twowire_location_sel_o, converter_trigger_sel_o;
  logic port_a_bit0_o, port_a_bit0_oe_o;
  // Counters of checks, cycles and observed pulses
  int bad_count = 0, checks = 0, cyc = 0, dbg_n = 0, wd_n = 0, ill_n = 0, lpo_n = 0;
  bit lpo_run = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  sop_top #(.BUS_OVF1(16), .BUS_OVF2(32), .BUS_OVF3(64), .PART_NUM(PN), .REV_NUM(RV)) sop_top_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cpu_addr_i(cpu_addr_i), .cpu_wr_i(cpu_wr_i),
    .cpu_rd_i(cpu_rd_i), .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o),
    .bdm_addr_i(bdm_addr_i), .bdm_wr_i(bdm_wr_i), .bdm_wdata_i(bdm_wdata_i),
    .lpo_clk_i(lpo_clk_i), .stop_exec_i(stop_exec_i), .debug_reset_o(debug_reset_o),
    .watchdog_reset_o(watchdog_reset_o), .illegal_opcode_reset_o(illegal_opcode_reset_o),
    .stop_allow_o(stop_allow_o), .serial2_location_sel_o(serial2_location_sel_o),
    .twowire_location_sel_o(twowire_location_sel_o), .converter_trigger_sel_o(converter_trigger_sel_o),
    .port_a_bit0_o(port_a_bit0_o), .port_a_bit0_oe_o(port_a_bit0_oe_o));
  ////////////////////////////////////////////////////////////////////////////////
  // Bus clock, 8 ns period
  initial
  begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // Slow clock stand-in, runs only inside its test, 10 bus cycles a period
  always #40 if (lpo_run) lpo_clk_i = ~lpo_clk_i;
  always @(posedge lpo_clk_i) lpo_n++;
  // Pulse counters and hang guard
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (debug_reset_o === 1'b1) dbg_n++;
    if (watchdog_reset_o === 1'b1) wd_n++;
    if (illegal_opcode_reset_o === 1'b1) ill_n++;
    if (cyc == 40000)
    begin
      bad_count++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // Reset held three cycles, released off the edge
  task automatic do_reset();
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
  endtask : do_reset
  // CPU write: one-cycle strobe, then one settling cycle so pulses are counted
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cpu_addr_i = a;
    cpu_wdata_i = d;
    cpu_wr_i = 1'b1;
    @(negedge ref_clk_i);
    cpu_wr_i = 1'b0;
    @(negedge ref_clk_i);
  endtask : wr
  // Back-to-back write pair: strobe held high, data changed after the first edge
  task automatic wr_pair(input logic [3:0] a, input logic [7:0] d0, input logic [7:0] d1);
    cpu_addr_i = a;
    cpu_wdata_i = d0;
    cpu_wr_i = 1'b1;
    @(negedge ref_clk_i);
    cpu_wdata_i = d1;
    @(negedge ref_clk_i);
    cpu_wr_i = 1'b0;
    @(negedge ref_clk_i);
  endtask : wr_pair
  // CPU read: data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    cpu_addr_i = a;
    cpu_rd_i = 1'b1;
    @(negedge ref_clk_i);
    cpu_rd_i = 1'b0;
    d = cpu_rdata_o;
    @(negedge ref_clk_i);
  endtask : rd
  // Debug host write
  task automatic bdm_wr(input logic [3:0] a, input logic [7:0] d);
    bdm_addr_i = a;
    bdm_wdata_i = d;
    bdm_wr_i = 1'b1;
    @(negedge ref_clk_i);
    bdm_wr_i = 1'b0;
    @(negedge ref_clk_i);
  endtask : bdm_wr
  // Wait for the next watchdog pulse, return cycles waited
  task automatic wait_wd(input int lim, output int t);
    int w0;
    w0 = wd_n;
    t = 0;
    while (wd_n == w0 && t < lim)
    begin
      @(negedge ref_clk_i);
      t++;
    end
  endtask : wait_wd
  // Clock out period for divide n: 2n cycles between rising edges
  task automatic clk_period(input logic [2:0] n);
    int t;
    wr(`SOP_ADDR_OPT2, {5'h00, n});
    t = 0;
    while (port_a_bit0_o !== 1'b0 && t < 40) begin @(negedge ref_clk_i); t++; end
    while (port_a_bit0_o !== 1'b1 && t < 40) begin @(negedge ref_clk_i); t++; end
    t = 0;
    do begin @(negedge ref_clk_i); t++; end while (port_a_bit0_o !== 1'b0 && t < 40);
    while (port_a_bit0_o !== 1'b1 && t < 40) begin @(negedge ref_clk_i); t++; end
    `SOP_CHK(t, 2 * int'(n))
    `SOP_CHK(port_a_bit0_oe_o, 1'b1)
  endtask : clk_period
  // Bus-clock watchdog: overflow, service, bad byte, windowed clear
  task automatic wd_bus(input logic [1:0] code, input int lim);
    int t, w;
    do_reset();
    wr(`SOP_ADDR_OPT1, {code, 6'h00});
    wr(`SOP_ADDR_OPT2, 8'h80);
    wait_wd(4 * lim, t);
    `SOP_CHK((t >= lim - 2 && t <= lim + 1), 1'b1)
    w = wd_n;
    repeat (8) wr_pair(`SOP_ADDR_RSC, `SOP_CLR_FIRST, `SOP_CLR_SECOND);
    `SOP_CHK(wd_n, w)
    wr(`SOP_ADDR_RSC, 8'h12);
    `SOP_CHK(wd_n, w + 1)
    do_reset();
    wr(`SOP_ADDR_OPT1, {code, 6'h00});
    wr(`SOP_ADDR_OPT2, 8'hC0);
    rd(`SOP_ADDR_OPT2, rv);
    `SOP_CHK(rv, 8'hC0)
    w = wd_n;
    wr(`SOP_ADDR_RSC, `SOP_CLR_FIRST);
    `SOP_CHK(wd_n, w + 1)
    wait_wd(4 * lim, t);
    repeat (lim - lim / 4 - 1) @(negedge ref_clk_i);
    w = wd_n;
    wr_pair(`SOP_ADDR_RSC, `SOP_CLR_FIRST, `SOP_CLR_SECOND);
    repeat (lim / 4) @(negedge ref_clk_i);
    `SOP_CHK(wd_n, w)
    $display("watchdog bus test code %0d done", code);
  endtask : wd_bus
  // Slow-clock watchdog: overflow after the documented number of rises
  task automatic wd_slow(input logic [1:0] code, input int edges);
    int t;
    do_reset();
    wr(`SOP_ADDR_OPT1, {code, 6'h00});
    lpo_n = 0;
    lpo_run = 1'b1;
    wait_wd(12 * edges, t);
    `SOP_CHK(lpo_n, edges)
    lpo_run = 1'b0;
    // Park the slow clock low so no false rise follows the next reset
    @(negedge ref_clk_i);
    lpo_clk_i = 1'b0;
    $display("watchdog slow test code %0d done", code);
  endtask : wd_slow
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    do_reset();
    rd(`SOP_ADDR_OPT1, rv);
    `SOP_CHK(rv, 8'hC0)
    rd(`SOP_ADDR_OPT2, rv);
    `SOP_CHK(rv, 8'h00)
    rd(`SOP_ADDR_IDH, rv);
    `SOP_CHK(rv, {RV, PN[11:8]})
    rd(`SOP_ADDR_IDL, rv);
    `SOP_CHK(rv, PN[7:0])
    wr(`SOP_ADDR_IDL, 8'h00);
    rd(`SOP_ADDR_IDL, rv);
    `SOP_CHK(rv, PN[7:0])
    rd(4'hF, rv);
    `SOP_CHK(rv, 8'h00)
    stop_exec_i = 1'b1;
    @(negedge ref_clk_i);
    stop_exec_i = 1'b0;
    @(negedge ref_clk_i);
    `SOP_CHK(ill_n, 1)
    $display("reset value test done");
    wr(`SOP_ADDR_DBG, 8'hFF);
    `SOP_CHK(dbg_n, 0)
    rd(`SOP_ADDR_DBG, rv);
    `SOP_CHK(rv, 8'h00)
    bdm_wr(`SOP_ADDR_DBG, 8'h01);
    `SOP_CHK(dbg_n, 1)
    bdm_wr(`SOP_ADDR_DBG, 8'h00);
    `SOP_CHK(dbg_n, 1)
    $display("debug reset test done");
    wr(`SOP_ADDR_OPT1, 8'h38);
    wr(`SOP_ADDR_OPT1, 8'hC0);
    rd(`SOP_ADDR_OPT1, rv);
    `SOP_CHK(rv, 8'h38)
    `SOP_CHK({stop_allow_o, serial2_location_sel_o, twowire_location_sel_o}, 3'h7)
    stop_exec_i = 1'b1;
    @(negedge ref_clk_i);
    stop_exec_i = 1'b0;
    @(negedge ref_clk_i);
    `SOP_CHK(ill_n, 1)
    wr(`SOP_ADDR_RSC, 8'h12);
    `SOP_CHK(wd_n, 0)
    wr(`SOP_ADDR_OPT2, 8'h17);
    wr(`SOP_ADDR_OPT2, 8'hEF);
    rd(`SOP_ADDR_OPT2, rv);
    `SOP_CHK(rv, 8'h07)
    `SOP_CHK(converter_trigger_sel_o, 1'b0)
    wr(`SOP_ADDR_OPT2, 8'h10);
    `SOP_CHK(converter_trigger_sel_o, 1'b1)
    $display("options test done");
    for (int n = 1; n < 8; n++) clk_period(n[2:0]);
    wr(`SOP_ADDR_OPT2, 8'h00);
    repeat (20) @(negedge ref_clk_i);
    `SOP_CHK({port_a_bit0_o, port_a_bit0_oe_o}, 2'h0)
    $display("clock out test done");
    wd_bus(`SOP_TO_ONE, 16);
    wd_bus(`SOP_TO_TWO, 32);
    wd_bus(2'h3, 64);
    wd_slow(`SOP_TO_ONE, 32);
    wd_slow(`SOP_TO_TWO, 256);
    wd_slow(2'h3, 1024);
    close_out();
  end
endmodule : sop_top_tb
`default_nettype wire
